// file: core/dpps_consts.svh
// Constants of the dual port select block: register offsets, field positions,
// reset values and the bit layout of the synchronised pin bundle.
// Assumes inclusion by bare name from the package; the top module relies on that include.
`ifndef DPPS_CONSTS_SVH
`define DPPS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define DPPS_OFF_CONFIG 8'h00
`define DPPS_OFF_TXCTL 8'h04
`define DPPS_OFF_PHYST 8'h08
`define DPPS_OFF_RXST 8'h0c
`define DPPS_OFF_RXDATA 8'h10
`define DPPS_OFF_TXDATA 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DPPS_CFG_SEL_BIT 15
`define DPPS_CFG_STEP_BIT 10
`define DPPS_CFG_AUI_BIT 8
`define DPPS_TXC_WRAP_BIT 1
`define DPPS_PHY_LINK_BIT 14
`define DPPS_PHY_CRS_BIT 0
`define DPPS_PHY_COL_BIT 1
`define DPPS_PHY_BUSY_BIT 2
`define DPPS_PHY_COLSEEN_BIT 3
`define DPPS_RXST_BADCRC_BIT 13
`define DPPS_RXST_VALID_BIT 15

// ----------------------------------------------------------------------------
// Reset values and unit counts
// ----------------------------------------------------------------------------
`define DPPS_RST_SEL 1'b0
`define DPPS_RST_STEP 1'b0
`define DPPS_RST_AUI 1'b0
`define DPPS_RST_WRAP 1'b0
`define DPPS_BYTE_BITS 4'h8
`define DPPS_ENDEC_STEP 4'h1
`define DPPS_MII_STEP 4'h4

// ----------------------------------------------------------------------------
// Synchronised pin bundle layout
// ----------------------------------------------------------------------------
`define DPPS_NIN 16
`define DPPS_IN_E_RXD 0
`define DPPS_IN_E_CRS 1
`define DPPS_IN_E_COL 2
`define DPPS_IN_E_TXC 3
`define DPPS_IN_E_RXC 4
`define DPPS_IN_LINK_N 5
`define DPPS_IN_M_CRS 6
`define DPPS_IN_M_DV 7
`define DPPS_IN_M_COL 8
`define DPPS_IN_M_TXC 9
`define DPPS_IN_M_RXC 10
`define DPPS_IN_M_ER 11
`define DPPS_IN_M_RXD 12
// Pull levels of the idle pins; synchroniser resets here to avoid false edges
`define DPPS_PIN_IDLE 16'h0639

`endif

// file: core/dpps_pkg.sv
// Types of the dual port select block.
// Assumes the constants header is on the include path.
`include "dpps_consts.svh"

package dpps_pkg;

  // --------------------------------------------------------------------------
  // Transmit sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic {
    DPPS_TX_IDLE,
    DPPS_TX_SEND
  } dpps_tx_state_t;

  // --------------------------------------------------------------------------
  // State of the synchroniser
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`DPPS_NIN-1:0] s1;
    logic [`DPPS_NIN-1:0] s2;
    logic [`DPPS_NIN-1:0] prev;
  } dpps_sync_state_t;

  // --------------------------------------------------------------------------
  // State of the top module
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic cfg_sel;
    logic step_n;
    logic aui;
    logic wrap;
    logic [31:0] rdata;
    dpps_tx_state_t tx_st;
    logic tx_pend;
    logic [7:0] tx_byte;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic etx_env;
    logic etxd;
    logic mtx_env;
    logic [3:0] mtxd;
    logic col_seen;
    logic rx_act;
    logic rx_err;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] rx_hold;
    logic rx_have;
    logic [7:0] rx_data;
    logic rx_valid;
    logic bad_crc;
  } dpps_state_t;

endpackage : dpps_pkg

// file: core/dpps_sync_if.sv
// Carrier between the synchroniser and the port logic.
// Assumes both ends run on the same system clock.
interface dpps_sync_if;
  logic [`DPPS_NIN-1:0] lvl;
  logic [`DPPS_NIN-1:0] rise;
  modport src (output lvl, output rise);
  modport dst (input lvl, input rise);
endinterface : dpps_sync_if

// file: core/dpps_sync.sv
// Two-stage synchroniser with rising edge detection for all pin inputs.
// Assumes the pins are asynchronous to clk_i and change slower than clk_i.
module dpps_sync
  import dpps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`DPPS_NIN-1:0] pins_i,
  dpps_sync_if.src sy
);

  dpps_sync_state_t q;
  dpps_sync_state_t d;

  // --------------------------------------------------------------------------
  // Next state: first stage feeds only the second stage
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = pins_i;
    d.s2 = q.s1;
    d.prev = q.s2;
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= {3{`DPPS_PIN_IDLE}}; // Idle levels, so no edge is seen after reset
    end else begin
      q <= d;
    end
  end

  // Edges come from stage two and its delayed copy only
  assign sy.lvl = q.s2;
  assign sy.rise = q.s2 & ~q.prev;

endmodule : dpps_sync

// file: core/dpps_port.sv
// Media side port logic: selects the serial encoder port or the nibble port.
// Assumes a 10 MHz clk_i, a plain register port and slow link clocks sampled
// as ordinary inputs.
//
// Behaviour
// R1: Encoder transmit envelope stays low whenever the nibble port is selected.
// R2: Encoder port sends transmit data on one serial NRZ output.
// R3: Encoder receive data, carrier, collision used only when encoder port selected.
// R4: Encoder supplies transmit and receive clocks; ignored while nibble port selected.
// R5: Wrap-test output follows transmit control bit 1 regardless of port.
// R6: Active-low link input reported as phy status bit 14, any port.
// R7: Step-mode output low-active, driven by inverse of configuration bit 10.
// R8: Port-select output follows configuration bit 15; high means nibble port.
// R9: Attachment-unit select output follows configuration bit 8, any port.
// R10: Nibble transmit envelope covers each transmission, low while encoder selected.
// R11: Nibble carrier used for deferral, ignored when encoder port selected.
// R12: Nibble receive data-valid frames received data, ignored for encoder port.
// R13: Nibble collision input used only while nibble port selected.
// R14: Nibble port transmit data goes out as 4-bit nibbles.
// R15: Nibble transceiver supplies transmit clock; ignored when encoder selected.
// R16: Nibble receive clock used only while nibble port selected.
// R17: Received nibbles accepted only while nibble port selected.
// R18: Nibble code error discards the frame and sets receive status bit 13.
// R19: Frame engine routed to exactly one port, chosen by port select.
// R20: Each port's received signals synchronised before reaching frame logic.
//
// Strobed register access and the address map were left to the implementer.
module dpps_port
  import dpps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic endec_rx_data_i,
  input wire logic endec_carrier_i,
  input wire logic endec_collision_i,
  input wire logic endec_tx_clock_i,
  input wire logic endec_rx_clock_i,
  output logic endec_tx_envelope_o,
  output logic endec_tx_data_o,
  input wire logic link_input_n_i,
  input wire logic mii_carrier_i,
  input wire logic mii_rx_valid_i,
  input wire logic mii_collision_i,
  input wire logic mii_tx_clock_i,
  input wire logic mii_rx_clock_i,
  input wire logic mii_rx_error_i,
  input wire logic [3:0] mii_rx_nibble_i,
  output logic mii_tx_envelope_o,
  output logic [3:0] mii_tx_nibble_o,
  output logic wrap_test_out_o,
  output logic step_mode_out_n_o,
  output logic port_select_out_o,
  output logic attach_unit_select_out_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Choose the nibble port signal when selected, else the encoder one
  function automatic logic dpps_pick(input logic sel, input logic mii, input logic enc);
    dpps_pick = sel ? mii : enc;
  endfunction : dpps_pick

  // Bits moved per link clock edge on the selected port
  function automatic logic [3:0] dpps_step(input logic sel);
    dpps_step = sel ? `DPPS_MII_STEP : `DPPS_ENDEC_STEP;
  endfunction : dpps_step

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  dpps_sync_if sy ();
  logic [`DPPS_NIN-1:0] pins;

  // Every pin passes two flops before any logic reads it (see R20)
  assign pins = {mii_rx_nibble_i, mii_rx_error_i, mii_rx_clock_i, mii_tx_clock_i,
                 mii_collision_i, mii_rx_valid_i, mii_carrier_i, link_input_n_i,
                 endec_rx_clock_i, endec_tx_clock_i, endec_collision_i,
                 endec_carrier_i, endec_rx_data_i};

  dpps_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i(pins),
    .sy(sy)
  );

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  dpps_state_t q;
  dpps_state_t d;

  // --------------------------------------------------------------------------
  // Next state: bus, transmit, receive
  // --------------------------------------------------------------------------
  always_comb begin
    logic sel;
    logic rsel;
    logic tclk;
    logic rclk;
    logic endec_carrier;
    logic col;
    logic env;
    logic [7:0] sh;
    logic [3:0] cnt;
    sel = 1'b0;
    rsel = 1'b0;
    tclk = 1'b0;
    rclk = 1'b0;
    endec_carrier = 1'b0;
    col = 1'b0;
    env = 1'b0;
    sh = 8'h00;
    cnt = 4'h0;
    d = q;
    d.rdata = 32'h0000_0000;

    // Register writes; configuration feeds the output pins directly
    if (wr_i) begin
      case (addr_i)
        `DPPS_OFF_CONFIG: begin
          d.cfg_sel = wdata_i[`DPPS_CFG_SEL_BIT];     // see R8
          d.step_n = ~wdata_i[`DPPS_CFG_STEP_BIT];    // see R7
          d.aui = wdata_i[`DPPS_CFG_AUI_BIT];         // see R9
        end
        `DPPS_OFF_TXCTL: begin
          d.wrap = wdata_i[`DPPS_TXC_WRAP_BIT];       // see R5
        end
        `DPPS_OFF_TXDATA: begin
          // A byte written while busy is dropped, software polls busy first
          if (!q.tx_pend && q.tx_st == DPPS_TX_IDLE) begin
            d.tx_pend = 1'b1;
            d.tx_byte = wdata_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; read-to-clear flags are cleared here, set later wins
    if (rd_i) begin
      case (addr_i)
        `DPPS_OFF_CONFIG: begin
          d.rdata[`DPPS_CFG_SEL_BIT] = q.cfg_sel;
          d.rdata[`DPPS_CFG_STEP_BIT] = ~q.step_n;
          d.rdata[`DPPS_CFG_AUI_BIT] = q.aui;
        end
        `DPPS_OFF_TXCTL: begin
          d.rdata[`DPPS_TXC_WRAP_BIT] = q.wrap;
        end
        `DPPS_OFF_PHYST: begin
          d.rdata[`DPPS_PHY_LINK_BIT] = sy.lvl[`DPPS_IN_LINK_N];  // see R6
          d.rdata[`DPPS_PHY_CRS_BIT] = dpps_pick(q.cfg_sel, sy.lvl[`DPPS_IN_M_CRS],
                                                 sy.lvl[`DPPS_IN_E_CRS]);
          d.rdata[`DPPS_PHY_COL_BIT] = dpps_pick(q.cfg_sel, sy.lvl[`DPPS_IN_M_COL],
                                                 sy.lvl[`DPPS_IN_E_COL]);
          d.rdata[`DPPS_PHY_BUSY_BIT] = q.tx_pend | (q.tx_st == DPPS_TX_SEND);
          d.rdata[`DPPS_PHY_COLSEEN_BIT] = q.col_seen;
          d.col_seen = 1'b0;
        end
        `DPPS_OFF_RXST: begin
          d.rdata[`DPPS_RXST_BADCRC_BIT] = q.bad_crc;
          d.rdata[`DPPS_RXST_VALID_BIT] = q.rx_valid;
          d.bad_crc = 1'b0;
        end
        `DPPS_OFF_RXDATA: begin
          d.rdata[7:0] = q.rx_data;
          d.rx_valid = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Transmit: one engine, steered to one port (see R19)
    // ------------------------------------------------------------------------
    // New selection is used so a port switch never leaves a stray envelope
    sel = d.cfg_sel;
    tclk = dpps_pick(sel, sy.rise[`DPPS_IN_M_TXC], sy.rise[`DPPS_IN_E_TXC]);  // see R4 R15
    endec_carrier = dpps_pick(sel, sy.lvl[`DPPS_IN_M_CRS], sy.lvl[`DPPS_IN_E_CRS]);     // see R11 R3
    col = dpps_pick(sel, sy.lvl[`DPPS_IN_M_COL], sy.lvl[`DPPS_IN_E_COL]);     // see R13 R3
    case (q.tx_st)
      DPPS_TX_IDLE: begin
        // Defer while the selected port sees carrier
        if (q.tx_pend && tclk && !endec_carrier) begin
          d.tx_st = DPPS_TX_SEND;
          d.tx_pend = 1'b0;
          d.tx_cnt = `DPPS_BYTE_BITS - dpps_step(sel);
          if (sel) begin
            d.mtxd = q.tx_byte[3:0];                 // see R14
            d.tx_sh = {4'h0, q.tx_byte[7:4]};
          end else begin
            d.etxd = q.tx_byte[0];                   // see R2
            d.tx_sh = {1'b0, q.tx_byte[7:1]};
          end
        end
      end
      DPPS_TX_SEND: begin
        if (sel != q.cfg_sel || col) begin
          // Port switch or collision ends the transmission at once
          d.tx_st = DPPS_TX_IDLE;
          d.col_seen = col ? 1'b1 : d.col_seen;
        end else if (tclk) begin
          if (q.tx_cnt == 4'h0) begin
            d.tx_st = DPPS_TX_IDLE;
          end else begin
            d.tx_cnt = q.tx_cnt - dpps_step(sel);
            if (sel) begin
              d.mtxd = q.tx_sh[3:0];                 // see R14
              d.tx_sh = {4'h0, q.tx_sh[7:4]};
            end else begin
              d.etxd = q.tx_sh[0];                   // see R2
              d.tx_sh = {1'b0, q.tx_sh[7:1]};
            end
          end
        end
      end
      default: begin
        d.tx_st = DPPS_TX_IDLE;
      end
    endcase

    // Envelopes only on the selected port; data lines idle low
    d.etx_env = (d.tx_st == DPPS_TX_SEND) && !sel;   // see R1
    d.mtx_env = (d.tx_st == DPPS_TX_SEND) && sel;    // see R10
    if (d.tx_st != DPPS_TX_SEND) begin
      d.etxd = 1'b0;
      d.mtxd = 4'h0;
    end

    // ------------------------------------------------------------------------
    // Receive: envelope, clock and data of the selected port only
    // ------------------------------------------------------------------------
    rsel = q.cfg_sel;
    env = dpps_pick(rsel, sy.lvl[`DPPS_IN_M_DV], sy.lvl[`DPPS_IN_E_CRS]);      // see R12 R3
    rclk = dpps_pick(rsel, sy.rise[`DPPS_IN_M_RXC], sy.rise[`DPPS_IN_E_RXC]);  // see R16 R4
    if (!q.rx_act && env) begin
      d.rx_act = 1'b1;
      d.rx_err = 1'b0;
      d.rx_cnt = 4'h0;
      d.rx_have = 1'b0;
    end
    if (env && rclk) begin
      if (rsel) begin
        sh = {sy.lvl[`DPPS_IN_M_RXD +: 4], q.rx_sh[7:4]};                 // see R17
        if (sy.lvl[`DPPS_IN_M_ER]) begin
          d.rx_err = 1'b1;                                                // see R18
        end
      end else begin
        sh = {sy.lvl[`DPPS_IN_E_RXD], q.rx_sh[7:1]};                      // see R3
      end
      cnt = d.rx_cnt + dpps_step(rsel);
      d.rx_sh = sh;
      if (cnt == `DPPS_BYTE_BITS) begin
        d.rx_hold = sh;
        d.rx_have = 1'b1;
        cnt = 4'h0;
      end
      d.rx_cnt = cnt;
    end
    // End of envelope: good frame posts its last byte, bad frame is dropped
    if (q.rx_act && !env) begin
      d.rx_act = 1'b0;
      if (q.rx_err) begin
        d.bad_crc = 1'b1;                                                 // see R18
      end else if (q.rx_have) begin
        d.rx_data = q.rx_hold;
        d.rx_valid = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cfg_sel <= `DPPS_RST_SEL;
      q.step_n <= ~`DPPS_RST_STEP;
      q.aui <= `DPPS_RST_AUI;
      q.wrap <= `DPPS_RST_WRAP;
      q.tx_st <= DPPS_TX_IDLE;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from flops
  // --------------------------------------------------------------------------
  assign rdata_o = q.rdata;
  assign endec_tx_envelope_o = q.etx_env;
  assign endec_tx_data_o = q.etxd;
  assign mii_tx_envelope_o = q.mtx_env;
  assign mii_tx_nibble_o = q.mtxd;
  assign wrap_test_out_o = q.wrap;
  assign step_mode_out_n_o = q.step_n;
  assign port_select_out_o = q.cfg_sel;
  assign attach_unit_select_out_o = q.aui;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_mii_quiet;
    port_select_out_o && !q.rx_act && !sy.lvl[`DPPS_IN_M_DV];
  endsequence

  sequence s_err_end;
    port_select_out_o && q.rx_act && q.rx_err && !sy.lvl[`DPPS_IN_M_DV];
  endsequence

  property p_r1;
    port_select_out_o |-> !endec_tx_envelope_o;
  endproperty
  a_r1: assert property (p_r1) else $error("encoder envelope high in nibble mode"); // see R1

  property p_r10;
    !port_select_out_o |-> !mii_tx_envelope_o;
  endproperty
  a_r10: assert property (p_r10) else $error("nibble envelope high in encoder mode"); // see R10

  property p_r5;
    (wr_i && addr_i == `DPPS_OFF_TXCTL) |=> wrap_test_out_o == $past(wdata_i[1]);
  endproperty
  a_r5: assert property (p_r5) else $error("wrap output not following bit"); // see R5

  property p_r7;
    (wr_i && addr_i == `DPPS_OFF_CONFIG) |=> step_mode_out_n_o == !$past(wdata_i[10]);
  endproperty
  a_r7: assert property (p_r7) else $error("step output not inverse of bit"); // see R7

  property p_r8;
    (wr_i && addr_i == `DPPS_OFF_CONFIG) |=> port_select_out_o == $past(wdata_i[15]);
  endproperty
  a_r8: assert property (p_r8) else $error("port select not following bit"); // see R8

  property p_r9;
    (wr_i && addr_i == `DPPS_OFF_CONFIG) |=> attach_unit_select_out_o == $past(wdata_i[8]);
  endproperty
  a_r9: assert property (p_r9) else $error("attach select not following bit"); // see R9

  property p_r6;
    (rd_i && addr_i == `DPPS_OFF_PHYST) |=> rdata_o[14] == $past(sy.lvl[`DPPS_IN_LINK_N]);
  endproperty
  a_r6: assert property (p_r6) else $error("link bit wrong in phy status"); // see R6

  property p_r3;
    s_mii_quiet |=> !q.rx_act;
  endproperty
  a_r3: assert property (p_r3) else $error("encoder carrier started a frame"); // see R3

  property p_r18;
    s_err_end |=> q.bad_crc && !q.rx_act;
  endproperty
  a_r18: assert property (p_r18) else $error("code error not reported"); // see R18

  property p_r14;
    $rose(mii_tx_envelope_o) |-> mii_tx_nibble_o == $past(q.tx_byte[3:0]);
  endproperty
  a_r14: assert property (p_r14) else $error("first nibble not low nibble"); // see R14

  property p_r2;
    $rose(endec_tx_envelope_o) |-> endec_tx_data_o == $past(q.tx_byte[0]);
  endproperty
  a_r2: assert property (p_r2) else $error("first serial bit not bit 0"); // see R2

endmodule : dpps_port

// file: testbench/dpps_phy_model.sv
// Far-side model: serial encoder and nibble transceiver clocks, frames, capture.
// Assumes the bench calls send and reads the capture queues hierarchically.
module dpps_phy_model (
  output logic etxc_o,
  output logic erxc_o,
  output logic erxd_o,
  output logic ecrs_o,
  output logic mtxc_o,
  output logic mrxc_o,
  output logic mdv_o,
  output logic mer_o,
  output logic [3:0] mrxd_o,
  input wire logic etxe_i,
  input wire logic etxd_i,
  input wire logic mtxe_i,
  input wire logic [3:0] mtxd_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic q_e[$];
  logic [3:0] q_m[$];
  // ----
  // Transmit clocks run free, 800 ns, offset so they never share a phase
  // ----
  initial begin
    etxc_o = 1'b1;
    forever #400 etxc_o = ~etxc_o;
  end
  initial begin
    mtxc_o = 1'b1;
    #130;
    forever #400 mtxc_o = ~mtxc_o;
  end
  // Receive side idles at pull levels; its clocks stand still between frames
  initial begin
    {erxc_o, mrxc_o, erxd_o, ecrs_o, mdv_o, mer_o, mrxd_o} = 10'h380;
  end
  // Capture mid-unit, well clear of the launching edge
  always @(negedge etxc_o) if (etxe_i === 1'b1) q_e.push_back(etxd_i);
  always @(negedge mtxc_o) if (mtxe_i === 1'b1) q_m.push_back(mtxd_i);
  // One byte frame, LSB or low nibble first; er flags a code error
  task send(input bit m, input logic [7:0] b, input bit er);
    int i;
    for (i = 0; i < (m ? 2 : 8); i++) begin
      if (m) begin
        mdv_o = 1'b1;
        mer_o = er;
        mrxd_o = i ? b[7:4] : b[3:0];
        mrxc_o = 1'b0;
      end else begin
        ecrs_o = 1'b1;
        erxd_o = b[i];
        erxc_o = 1'b0;
      end
      #400;
      mrxc_o = 1'b1;
      erxc_o = 1'b1;
      #400;
    end
    {ecrs_o, mdv_o, mer_o, erxd_o} = 4'h1;
    mrxd_o = ~mrxd_o; // No pull on the nibble: show the inverse once released
  endtask : send
endmodule : dpps_phy_model

// file: testbench/test_dual_phy_port_select.sv
// Self-checking bench for the port select block with a far-side model.
// Assumes the design files and the partner model are compiled first.
module test_dual_phy_port_select;
  import dpps_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wr_i, rd_i, endec_rx_data_i, endec_carrier_i, endec_collision_i;
  logic endec_tx_clock_i, endec_rx_clock_i, link_input_n_i, mii_carrier_i, mii_rx_valid_i;
  logic mii_collision_i, mii_tx_clock_i, mii_rx_clock_i, mii_rx_error_i;
  logic endec_tx_envelope_o, endec_tx_data_o, mii_tx_envelope_o, wrap_test_out_o;
  logic step_mode_out_n_o, port_select_out_o, attach_unit_select_out_o;
  logic [7:0] addr_i, b, eb;
  logic [31:0] wdata_i, rdata_o, r, d;
  logic [3:0] mii_rx_nibble_i, mii_tx_nibble_o;
  int n_fail, checked, cyc, bad, i;
  dpps_port uut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .endec_rx_data_i,
    .endec_carrier_i, .endec_collision_i, .endec_tx_clock_i, .endec_rx_clock_i,
    .endec_tx_envelope_o, .endec_tx_data_o, .link_input_n_i, .mii_carrier_i,
    .mii_rx_valid_i, .mii_collision_i, .mii_tx_clock_i, .mii_rx_clock_i, .mii_rx_error_i,
    .mii_rx_nibble_i, .mii_tx_envelope_o, .mii_tx_nibble_o, .wrap_test_out_o,
    .step_mode_out_n_o, .port_select_out_o, .attach_unit_select_out_o);
  dpps_phy_model phy (.etxc_o(endec_tx_clock_i), .erxc_o(endec_rx_clock_i),
    .erxd_o(endec_rx_data_i), .ecrs_o(endec_carrier_i), .mtxc_o(mii_tx_clock_i),
    .mrxc_o(mii_rx_clock_i), .mdv_o(mii_rx_valid_i), .mer_o(mii_rx_error_i),
    .mrxd_o(mii_rx_nibble_i), .etxe_i(endec_tx_envelope_o), .etxd_i(endec_tx_data_o),
    .mtxe_i(mii_tx_envelope_o), .mtxd_i(mii_tx_nibble_o));
  // ----
  // Clock, timeout and the wrong-port envelope watch
  // ----
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  always @(negedge clk_i) begin
    if (rst_i === 1'b0 && (port_select_out_o ? endec_tx_envelope_o : mii_tx_envelope_o) !== 1'b0)
      bad++;
  end
  // ----
  // Bus cycles and comparison
  // ----
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    v = rdata_o; // Data stand only in the cycle after the strobe
  endtask : rd
  // Bounded wait for an envelope level, sampled away from the edge
  task wenv(input bit m, input logic v);
    int k;
    k = 0;
    while ((m ? mii_tx_envelope_o : endec_tx_envelope_o) !== v && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    chk(k < 300, 1, "envelope wait");
  endtask : wenv
  task give_verdict();
    $display("fails %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // ----
  // Main sequence
  // ----
  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = 43'h400_0000_0000;
    {link_input_n_i, mii_carrier_i, mii_collision_i, endec_collision_i} = 4'h8;
    r = $urandom(32'h9c3f2ece);
    repeat (20) @(posedge clk_i);
    chk({wrap_test_out_o, step_mode_out_n_o, port_select_out_o, attach_unit_select_out_o,
      endec_tx_envelope_o, mii_tx_envelope_o}, 6'b010000, "reset pins");
    rst_i <= 1'b0;
    // Static pins track configuration and pin levels
    for (i = 0; i < 6; i++) begin
      r = $urandom;
      wr(8'h00, r & 32'h8500);
      wr(8'h04, r & 32'h2);
      link_input_n_i <= r[4];
      repeat (4) @(negedge clk_i);
      chk({wrap_test_out_o, step_mode_out_n_o, port_select_out_o, attach_unit_select_out_o},
        {r[1], ~r[10], r[15], r[8]}, "static pins");
      rd(8'h00, d);
      chk(d, r & 32'h8500, "config readback");
      rd(8'h08, d);
      chk(d[14], r[4], "link bit");
    end
    // Encoder transmit: one byte, serial LSB first
    wr(8'h00, 32'h0);
    b = 8'($urandom);
    wr(8'h14, b);
    wenv(0, 1'b1);
    wenv(0, 1'b0);
    chk(phy.q_e.size(), 8, "serial bit count");
    for (i = 0; i < 8; i++) eb[i] = phy.q_e[i];
    chk(eb, b, "serial byte");
    // Encoder receive
    b = 8'($urandom);
    phy.send(0, b, 0);
    repeat (10) @(posedge clk_i);
    rd(8'h0c, d);
    chk({d[15], d[13]}, 2'b10, "serial rx status");
    rd(8'h10, d);
    chk(d[7:0], b, "serial rx byte");
    // Nibble port: deferral while carrier, encoder collision ignored
    wr(8'h00, 32'h8000);
    mii_carrier_i <= 1'b1;
    endec_collision_i <= 1'b1;
    b = 8'($urandom);
    wr(8'h14, b);
    repeat (40) @(negedge clk_i);
    chk(mii_tx_envelope_o, 1'b0, "deferral");
    rd(8'h08, d);
    chk(d[0], 1'b1, "carrier of selected port");
    mii_carrier_i <= 1'b0;
    wenv(1, 1'b1);
    wenv(1, 1'b0);
    @(posedge clk_i);
    endec_collision_i <= 1'b0;
    chk(phy.q_m.size(), 2, "nibble count");
    chk({phy.q_m[1], phy.q_m[0]}, b, "nibble byte");
    // Encoder frame ignored while the nibble port is selected
    phy.send(0, 8'h5a, 0);
    repeat (10) @(posedge clk_i);
    rd(8'h0c, d);
    chk(d[15], 1'b0, "unselected rx ignored");
    // Nibble receive, good then code error
    b = 8'($urandom);
    phy.send(1, b, 0);
    repeat (10) @(posedge clk_i);
    rd(8'h10, d);
    chk(d[7:0], b, "nibble rx byte");
    phy.send(1, ~b, 1);
    repeat (10) @(posedge clk_i);
    rd(8'h0c, d);
    chk({d[15], d[13]}, 2'b01, "code error");
    // Collision in mid-frame aborts and is recorded
    wr(8'h14, 32'h3c);
    wenv(1, 1'b1);
    @(posedge clk_i);
    mii_collision_i <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk(mii_tx_envelope_o, 1'b0, "collision abort");
    @(posedge clk_i);
    mii_collision_i <= 1'b0;
    rd(8'h08, d);
    chk(d[3], 1'b1, "collision seen");
    chk(bad, 0, "wrong port envelope");
    give_verdict();
  end
endmodule : test_dual_phy_port_select
